// ===== rtl/uhp_host_port.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1 - three select lines choose the register
// RULE2 - eight-bit data bus, driven on reads only
// RULE3 - strap high selects separate read/write strobes
// RULE4 - read strobe fall returns selected register byte
// RULE5 - host latches read byte at strobe rise
// RULE6 - write strobe rise stores the bus byte
// RULE7 - strap low: write pin is direction line
// RULE8 - act only while chip select is low
// RULE9 - strobe style: interrupt high, enabled by bit3
// RULE10 - direction style: interrupt low, open drain
// RULE11 - normal serial mode: transmit idles high
// RULE12 - infrared mode: encoded paths, idle low
// RULE13 - never drive bus on writes or deselected
module uhp_host_port (
    input wire logic clk, // 125 MHz system clock
    input wire logic rst_b, // async reset, active low
    input wire logic bus_style_strap, // 1 strobe style, 0 direction style
    input wire logic chip_sel_n, // chip select, active low
    input wire logic read_strobe_n, // read strobe, active low
    input wire logic write_strobe_n, // write strobe or direction line
    input wire logic reg_select_2, // register select bit 2
    input wire logic reg_select_1, // register select bit 1
    input wire logic reg_select_0, // register select bit 0
    input wire logic [7:0] host_data_in, // data bus level seen at pins
    output logic [7:0] host_data_out, // data bus drive value
    output logic host_data_oe, // data bus drive enable
    input wire logic bus_isolate_input, // isolates host bus when high
    input wire logic irq_request, // interrupt request from core
    output logic irq_out, // interrupt pin drive value
    output logic irq_oe, // interrupt pin drive enable
    input wire logic tx_bit, // serial bit from transmitter
    input wire logic tx_active, // transmitter is sending data
    output logic tx_serial, // transmit pin
    input wire logic rx_serial, // receive pin
    output logic rx_bit // decoded receive bit to core
);
    logic [2:0] sel_s;
    logic [7:0] data_s;
    logic cs_n_s;
    logic rd_n_s;
    logic wr_n_s;
    logic strap_s;
    logic iso_s;
    logic rx_s;
    logic style_q;
    logic style_valid_q;
    logic [1:0] settle_q;
    logic [7:0] regs_q [uhp_pkg::NUM_REGS];
    logic [7:0] modem_control_reg;
    logic cs_act;
    logic rd_act;
    logic wr_act;
    uhp_pkg::uhp_state_e state_q;
    uhp_pkg::uhp_state_e state_d;

    uhp_sync #(.WIDTH(3), .RST_VAL(3'h0)) u_sync_sel (
        .clk(clk),
        .rst_b(rst_b),
        .d({reg_select_2, reg_select_1, reg_select_0}),
        .q(sel_s)
    );
    uhp_sync #(.WIDTH(8), .RST_VAL(8'h00)) u_sync_data (
        .clk(clk),
        .rst_b(rst_b),
        .d(host_data_in),
        .q(data_s)
    );
    // idle levels: deselected, strobes high, strap high, isolated, receive high
    uhp_sync #(.WIDTH(6), .RST_VAL(6'h3F)) u_sync_ctl (
        .clk(clk),
        .rst_b(rst_b),
        .d({chip_sel_n, read_strobe_n, write_strobe_n, bus_style_strap,
            bus_isolate_input, rx_serial}),
        .q({cs_n_s, rd_n_s, wr_n_s, strap_s, iso_s, rx_s})
    );

    // strap caught once, after the synchroniser has flushed its reset value
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            style_q <= uhp_pkg::STYLE_STROBE;
            style_valid_q <= 1'b0;
            settle_q <= 2'h0;
        end else if (!style_valid_q) begin
            if (settle_q == 2'(uhp_pkg::SYNC_STAGES)) begin
                style_q <= strap_s; // RULE3 RULE7
                style_valid_q <= 1'b1;
            end else begin
                settle_q <= settle_q + 2'h1;
            end
        end
    end

    assign modem_control_reg = regs_q[uhp_pkg::MODEM_CTRL_IDX];
    assign cs_act = !cs_n_s && !iso_s && style_valid_q; // RULE8

    always_comb begin
        if (style_q == uhp_pkg::STYLE_STROBE) begin
            rd_act = cs_act && !rd_n_s; // RULE3
            wr_act = cs_act && !wr_n_s; // RULE3
        end else begin
            rd_act = cs_act && (wr_n_s == uhp_pkg::DIR_READ); // RULE7
            wr_act = cs_act && (wr_n_s == uhp_pkg::DIR_WRITE); // RULE7
        end
    end

    // transaction tracking: a cycle ends when its active term drops
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            uhp_pkg::UHP_IDLE: begin
                if (rd_act) begin
                    state_d = uhp_pkg::UHP_READ; // RULE4
                end else if (wr_act) begin
                    state_d = uhp_pkg::UHP_WRITE; // RULE6
                end
            end
            uhp_pkg::UHP_READ: begin
                if (!rd_act) begin
                    state_d = uhp_pkg::UHP_IDLE;
                end
            end
            uhp_pkg::UHP_WRITE: begin
                if (!wr_act) begin
                    state_d = uhp_pkg::UHP_IDLE;
                end
            end
            default: begin
                state_d = uhp_pkg::UHP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= uhp_pkg::UHP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // register store at end of write cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < uhp_pkg::NUM_REGS; i++) begin
                regs_q[i] <= uhp_pkg::REG_RST;
            end
        end else if (state_q == uhp_pkg::UHP_WRITE && !wr_act) begin
            regs_q[sel_s] <= data_s; // RULE1 RULE6
        end
    end

    // read byte latched at start of read, driven while read lasts
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            host_data_out <= uhp_pkg::DATA_OUT_RST;
        end else if (state_q == uhp_pkg::UHP_IDLE && rd_act) begin
            host_data_out <= regs_q[sel_s]; // RULE1 RULE4
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            host_data_oe <= 1'b0;
        end else begin
            host_data_oe <= rd_act && !wr_act; // RULE2 RULE13
        end
    end

    // interrupt pin style follows bus style
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_out <= 1'b0;
            irq_oe <= 1'b0;
        end else if (style_q == uhp_pkg::STYLE_STROBE) begin
            irq_out <= irq_request; // RULE9
            irq_oe <= modem_control_reg[uhp_pkg::MCR_INT_EN_BIT]; // RULE9
        end else begin
            irq_out <= 1'b0; // RULE10
            irq_oe <= irq_request; // RULE10
        end
    end

    // serial line levels for normal and infrared modes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_serial <= uhp_pkg::TX_IDLE_NORMAL; // RULE11
            rx_bit <= 1'b1;
        end else if (modem_control_reg[uhp_pkg::MCR_IR_MODE_BIT]) begin
            tx_serial <= tx_active ? !tx_bit : uhp_pkg::TX_IDLE_IR; // RULE12
            rx_bit <= !rx_s; // RULE12
        end else begin
            tx_serial <= tx_active ? tx_bit : uhp_pkg::TX_IDLE_NORMAL; // RULE11
            rx_bit <= rx_s; // RULE11
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_read_drives_byte: assert property ( // RULE4
        (state_q == uhp_pkg::UHP_IDLE && rd_act) |=>
            host_data_oe && host_data_out == $past(regs_q[sel_s]))
        else $error("read start did not drive selected byte");
    a_no_drive_deselect: assert property ( // RULE13
        $past(!cs_act) |-> !host_data_oe)
        else $error("data bus driven while deselected");
    a_no_drive_write: assert property ( // RULE2
        $past(wr_act) |-> !host_data_oe)
        else $error("data bus driven during write");
    a_write_stores: assert property ( // RULE6
        (state_q == uhp_pkg::UHP_WRITE && !wr_act) |=>
            regs_q[$past(sel_s)] == $past(data_s))
        else $error("write byte not stored");
    a_dir_write_idle: assert property ( // RULE7
        (style_q == uhp_pkg::STYLE_DIRECTION && cs_act && !wr_n_s) |=> !host_data_oe)
        else $error("direction low treated as read");
    a_cs_gates_fsm: assert property ( // RULE8
        (state_q == uhp_pkg::UHP_IDLE && !cs_act) |=> state_q == uhp_pkg::UHP_IDLE)
        else $error("transaction began without chip select");
    a_irq_strobe: assert property ( // RULE9
        (style_q == uhp_pkg::STYLE_STROBE) ##1 (style_q == uhp_pkg::STYLE_STROBE) |->
            irq_oe == $past(modem_control_reg[uhp_pkg::MCR_INT_EN_BIT]) && irq_out == $past(irq_request))
        else $error("strobe style interrupt pin wrong");
    a_irq_open_drain: assert property ( // RULE10
        (style_q == uhp_pkg::STYLE_DIRECTION) ##1 (style_q == uhp_pkg::STYLE_DIRECTION) |->
            !irq_out && irq_oe == $past(irq_request))
        else $error("open drain interrupt pin wrong");
    a_tx_idle_normal: assert property ( // RULE11
        (!modem_control_reg[uhp_pkg::MCR_IR_MODE_BIT] && !tx_active) |=> tx_serial)
        else $error("normal transmit idle not high");
    a_tx_idle_ir: assert property ( // RULE12
        (modem_control_reg[uhp_pkg::MCR_IR_MODE_BIT] && !tx_active) |=> !tx_serial)
        else $error("infrared transmit idle not low");

    // data bus drive follows the read term, masked by the write term
    a_oe_only_read: assert property ( // RULE13
        host_data_oe |-> $past(rd_act) && !$past(wr_act))
        else $error("data bus driven without read term");
    a_oe_released: assert property ( // RULE2
        !rd_act |=> !host_data_oe)
        else $error("data bus not released after read");
    a_read_holds: assert property ( // RULE2
        (state_q == uhp_pkg::UHP_READ && rd_act && !wr_act) |=> host_data_oe)
        else $error("data bus dropped during read");
    a_strobe_read: assert property ( // RULE3
        (style_q == uhp_pkg::STYLE_STROBE && cs_act && !rd_n_s && wr_n_s) |=> host_data_oe)
        else $error("strobe style read not driven");
    a_dir_read: assert property ( // RULE7
        (style_q == uhp_pkg::STYLE_DIRECTION && cs_act && wr_n_s) |=> host_data_oe)
        else $error("direction high not treated as read");
    a_style_frozen: assert property ( // RULE3
        style_valid_q |=> $stable(style_q))
        else $error("bus style changed after capture");

    // serial data paths in both modes
    a_tx_data_normal: assert property ( // RULE11
        (!modem_control_reg[uhp_pkg::MCR_IR_MODE_BIT] && tx_active) |=> tx_serial == $past(tx_bit))
        else $error("normal transmit bit wrong");
    a_tx_data_ir: assert property ( // RULE12
        (modem_control_reg[uhp_pkg::MCR_IR_MODE_BIT] && tx_active) |=> tx_serial == !$past(tx_bit))
        else $error("infrared transmit bit wrong");
    a_rx_decode_ir: assert property ( // RULE12
        modem_control_reg[uhp_pkg::MCR_IR_MODE_BIT] |=> rx_bit == !$past(rx_s))
        else $error("infrared receive bit wrong");
    a_rx_normal: assert property ( // RULE11
        !modem_control_reg[uhp_pkg::MCR_IR_MODE_BIT] |=> rx_bit == $past(rx_s))
        else $error("normal receive bit wrong");

    c_read_cycle: cover property (
        state_q == uhp_pkg::UHP_READ ##1 state_q == uhp_pkg::UHP_IDLE);
    c_write_cycle: cover property (
        state_q == uhp_pkg::UHP_WRITE ##1 state_q == uhp_pkg::UHP_IDLE);
    c_dir_style_read: cover property (
        style_q == uhp_pkg::STYLE_DIRECTION && host_data_oe);
    c_ir_mode: cover property (modem_control_reg[uhp_pkg::MCR_IR_MODE_BIT] && tx_active);
    c_open_drain_irq: cover property (
        style_q == uhp_pkg::STYLE_DIRECTION && irq_oe);
endmodule : uhp_host_port

// ===== rtl/uhp_pkg.sv
package uhp_pkg;
    localparam int unsigned SEL_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_REGS = 8;
    localparam int unsigned SYNC_STAGES = 2;
    // modem control register position and fields
    localparam logic [2:0] MODEM_CTRL_IDX = 3'h4;
    localparam int unsigned MCR_INT_EN_BIT = 3;
    localparam int unsigned MCR_IR_MODE_BIT = 6;
    // reset values, idle levels and bus encodings
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] DATA_OUT_RST = 8'h00;
    localparam logic TX_IDLE_NORMAL = 1'b1;
    localparam logic TX_IDLE_IR = 1'b0;
    localparam logic STROBE_IDLE = 1'b1;
    localparam logic STYLE_STROBE = 1'b1;
    localparam logic STYLE_DIRECTION = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam logic DIR_WRITE = 1'b0;
    typedef enum logic [2:0] {
        UHP_IDLE  = 3'b001,
        UHP_READ  = 3'b010,
        UHP_WRITE = 3'b100
    } uhp_state_e;
endpackage : uhp_pkg

// ===== rtl/uhp_sync.sv
`timescale 1ns/1ps
module uhp_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic [WIDTH-1:0] d, // asynchronous input
    output logic [WIDTH-1:0] q // synchronised output
);
    logic [WIDTH-1:0] meta_q;

    // first stage read only by the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : uhp_sync

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic strap = 1'b1;
    logic iso = 1'b0;
    logic irq_req = 1'b0;
    logic tx_bit = 1'b0;
    logic tx_act = 1'b0;
    logic rx_ser = 1'b1;
    logic cs_n, rd_n, wr_n, doe, irq_out, irq_oe, tx_ser, rx_bit, clash;
    logic [2:0] sel;
    logic [7:0] bus, dout;
    int n_fail = 0;
    int n_checks = 0;
    always #4 clk = ~clk;
    uhp_host_port uhp_host_port_inst (.clk(clk), .rst_b(rst_b), .bus_style_strap(strap),
        .chip_sel_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .reg_select_2(sel[2]), .reg_select_1(sel[1]), .reg_select_0(sel[0]),
        .host_data_in(bus), .host_data_out(dout), .host_data_oe(doe),
        .bus_isolate_input(iso), .irq_request(irq_req), .irq_out(irq_out), .irq_oe(irq_oe),
        .tx_bit(tx_bit), .tx_active(tx_act), .tx_serial(tx_ser), .rx_serial(rx_ser),
        .rx_bit(rx_bit));
    uhp_host_model uhp_host_model_inst (.clk(clk), .strobe_style(strap),
        .host_data_out(dout), .host_data_oe(doe), .chip_sel_n(cs_n), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .sel(sel), .bus(bus), .clash(clash));
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task stop_test;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task do_reset(input logic s);
        @(negedge clk);
        rst_b = 1'b0;
        strap = s;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
    endtask : do_reset
    task acc(input logic [2:0] a, input logic w, input logic [7:0] d, input logic cs,
             output logic [7:0] q);
        uhp_host_model_inst.access(a, w, d, cs, q);
    endtask : acc
    task t_reset;
        check("tx idle", tx_ser, 8'h01);
        check("bus drive", doe, 8'h00);
        check("irq enable", irq_oe, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task t_regs;
        logic [7:0] q;
        for (int i = 0; i < 8; i++) acc(i[2:0], 1'b1, 8'h5A ^ (i[7:0] * 8'h13), 1'b1, q);
        acc(3'h2, 1'b1, 8'hC3, 1'b0, q);
        iso = 1'b1;
        acc(3'h5, 1'b1, 8'h3C, 1'b1, q);
        iso = 1'b0;
        acc(3'h3, 1'b0, 8'h00, 1'b0, q);
        check("no drive", {7'h00, uhp_host_model_inst.oe_seen}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            acc(i[2:0], 1'b0, 8'h00, 1'b1, q);
            check("reg read", q, 8'h5A ^ (i[7:0] * 8'h13));
        end
        check("bus clash", clash, 8'h00);
        $display("strobe register test done");
    endtask : t_regs
    task t_irq_ir;
        logic [7:0] q;
        acc(3'h4, 1'b1, 8'h48, 1'b1, q);
        irq_req = 1'b1;
        repeat (4) @(negedge clk);
        check("irq out", {irq_oe, irq_out}, 8'h03);
        check("ir idle", tx_ser, 8'h00);
        tx_act = 1'b1;
        tx_bit = 1'b0;
        rx_ser = 1'b0;
        repeat (4) @(negedge clk);
        check("ir tx", tx_ser, 8'h01);
        check("ir rx", rx_bit, 8'h01);
        irq_req = 1'b0;
        acc(3'h4, 1'b1, 8'h00, 1'b1, q);
        check("irq off", irq_oe, 8'h00);
        check("tx data", tx_ser, 8'h00);
        check("rx data", rx_bit, 8'h00);
        tx_act = 1'b0;
        tx_bit = 1'b0;
        repeat (4) @(negedge clk);
        check("tx idle", tx_ser, 8'h01);
        $display("interrupt and infrared test done");
    endtask : t_irq_ir
    task t_dir;
        logic [7:0] q;
        do_reset(1'b0);
        acc(3'h6, 1'b1, 8'hA5, 1'b1, q);
        acc(3'h1, 1'b1, 8'h7E, 1'b0, q);
        acc(3'h6, 1'b0, 8'h00, 1'b1, q);
        check("dir read", q, 8'hA5);
        acc(3'h1, 1'b0, 8'h00, 1'b1, q);
        check("dir deselected", q, 8'h00);
        acc(3'h6, 1'b0, 8'h00, 1'b0, q);
        check("dir no drive", {7'h00, uhp_host_model_inst.oe_seen}, 8'h00);
        irq_req = 1'b1;
        repeat (4) @(negedge clk);
        check("irq drain", {irq_oe, irq_out}, 8'h02);
        irq_req = 1'b0;
        repeat (4) @(negedge clk);
        check("irq release", irq_oe, 8'h00);
        check("bus clash", clash, 8'h00);
        $display("direction test done");
    endtask : t_dir
    initial begin
        #(8 * 20000);
        n_fail++;
        stop_test();
    end
    initial begin
        do_reset(1'b1);
        t_reset();
        t_regs();
        t_irq_ir();
        t_dir();
        stop_test();
    end
endmodule : testbench

// ===== verification/uhp_host_model.sv
`timescale 1ns/1ps
module uhp_host_model (
    input wire logic clk, // system clock
    input wire logic strobe_style, // strobe style bus in use
    input wire logic [7:0] host_data_out, // device drive value
    input wire logic host_data_oe, // device drive enable
    output logic chip_sel_n, // chip select, active low
    output logic read_strobe_n, // read strobe, active low
    output logic write_strobe_n, // write strobe or direction
    output logic [2:0] sel, // register select
    output logic [7:0] bus, // data bus level at pins
    output logic clash // both sides drove the bus
);
    logic [7:0] drv = 8'h00;
    logic hdrv = 1'b0;
    logic [7:0] last_q = 8'h00;
    // set when the device drove the bus during the last access
    logic oe_seen = 1'b0;
    // bus has no pull, so an undriven bus shows a changing pattern
    assign bus = host_data_oe ? host_data_out : (hdrv ? drv : ~last_q);
    always @(posedge clk) last_q <= bus;
    always @(posedge clk) if (hdrv && host_data_oe) clash <= 1'b1;
    initial begin
        clash = 1'b0;
        chip_sel_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        sel = 3'h0;
    end
    task automatic access(input logic [2:0] a, input logic wr, input logic [7:0] d,
                          input logic cs_on, output logic [7:0] q);
        @(negedge clk);
        sel = a;
        drv = d;
        hdrv = wr;
        chip_sel_n = ~cs_on;
        if (strobe_style) read_strobe_n = wr;
        write_strobe_n = ~wr;
        oe_seen = 1'b0;
        repeat (6) begin
            @(negedge clk);
            oe_seen = oe_seen | host_data_oe;
        end
        q = bus;
        chip_sel_n = 1'b1;
        read_strobe_n = 1'b1;
        if (strobe_style) write_strobe_n = 1'b1;
        // data and select held past the commit point
        repeat (4) @(negedge clk);
        hdrv = 1'b0;
        write_strobe_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask : access
endmodule : uhp_host_model
